/* hw/lcd_bias_supervisor_sequencer.sv */
// Local design decisions: strobed register access and the register addresses.
`timescale 1ns/1ps
// Function
// - Output below 70% over 50 ms disables
// - Faults clear only by power-on reset
// - Output below 30% disables at once
// - Timing-controller reset is active low
// - Reset timer starts after core soft-start
// - Reset width selectable 2 to 16 ms
// - Released reset latched high until power-down
// - Threshold bit picks lockout or detect level
// - Timing-controller reset is open drain
// - Shaping input high: pass on, discharge off
// - Shaping input low: pass off, discharge on
// - Power-up forces discharge until shaping delay
// - Shaping delay programmable 0 to 35 ms
// - Power-down forces pass on, discharge off
// - Mode bit selects gate-in-panel or conventional
// - Conventional mode: low while supply below detect
// - Detect threshold set by its register
// - Gate-in-panel mode: low until shaping delay
// - Gate-driver reset is open drain
// - Seven-bit code, larger code sinks more
// - Sink current is (N+1)/128 of reference
// - Configuration register at 00h, default 00h
// - Reset width register at 08h, default 01h
// - Shaping delay register at 0Ah, default 04h
module lcd_bias_supervisor_sequencer
#(
	parameter int MS_CYCLES_P = lcd_bias_pkg::MS_CYCLES,
	parameter int NUM_REG_P = lcd_bias_pkg::NUM_REGULATORS
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	input wire logic [NUM_REG_P-1:0] below_uv_level_i,
	input wire logic [NUM_REG_P-1:0] below_sc_level_i,
	input wire logic input_supply_above_lockout_i,
	input wire logic input_supply_above_detect_i,
	input wire logic core_rail_ramp_done_i,
	input wire logic gate_high_rail_ramp_done_i,
	input wire logic shaping_ctrl_in_i,
	input wire logic tcon_reset_n_i,
	output logic tcon_reset_n_o,
	output logic tcon_reset_n_oe_o,
	input wire logic gate_driver_reset_n_i,
	output logic gate_driver_reset_n_o,
	output logic gate_driver_reset_n_oe_o,
	output logic pass_switch_o,
	output logic discharge_switch_o,
	output logic chip_enable_o,
	output logic [7:0] detect_threshold_o,
	output logic [6:0] vcom_code_o,
	output logic [7:0] dac_sink_steps_o
);
	import lcd_bias_pkg::*;

	localparam int DIV_W = $clog2(MS_CYCLES_P + 1);
	localparam logic [7:0] UV_LIMIT = 8'(UV_TIME_MS + 1);

	if (MS_CYCLES_P < 1) begin : g_bad_div
		$error("MS_CYCLES_P must be at least one");
	end
	if (NUM_REG_P < 1 || NUM_REG_P > 8) begin : g_bad_reg
		$error("NUM_REG_P must lie between 1 and 8");
	end

	pwr_state_t state_r;
	pwr_state_t state_nxt;
	logic [DIV_W-1:0] div_r;
	logic ms_tick_r;
	logic [7:0] config_r;
	logic [7:0] reset_width_r;
	logic [7:0] shape_delay_r;
	logic [7:0] detect_r;
	logic [6:0] vcom_r;
	logic uv_fault_r;
	logic sc_fault_r;
	logic tcon_released_r;
	logic [NUM_REG_P-1:0] uv_done;
	logic reset_timer_done;
	logic shape_done;
	logic [7:0] reset_limit;
	logic [7:0] shape_limit;
	logic fault_any;
	logic supply_ok;
	logic powering_down;
	logic gip_mode;
	logic regs_enabled;
	logic [7:0] status_word;

	assign gip_mode = config_r[GIP_MODE_BIT];
	assign reset_limit = 8'((reset_width_r[2:0] + 8'h01) * RESET_STEP_MS);
	assign shape_limit = 8'(shape_delay_r[2:0] * SHAPE_STEP_MS);
	assign fault_any = uv_fault_r || sc_fault_r;
	// Selected power-down threshold
	assign supply_ok = config_r[THRESH_SEL_BIT] ? input_supply_above_detect_i
		: input_supply_above_lockout_i;
	assign powering_down = (state_r == PWR_DOWN);
	// Rails are watched only while the regulators are meant to be up
	assign regs_enabled = (state_r == PWR_UP || state_r == PWR_ON);

	// Millisecond enable
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r <= '0;
			ms_tick_r <= 1'b0;
		end else if (div_r == DIV_W'(MS_CYCLES_P - 1)) begin
			div_r <= '0;
			ms_tick_r <= 1'b1;
		end else begin
			div_r <= div_r + DIV_W'(1);
			ms_tick_r <= 1'b0;
		end
	end

	// Per-regulator undervoltage qualification, restarted on recovery
	for (genvar i = 0; i < NUM_REG_P; i++) begin : g_uv
		ms_timer u_uv_timer (
			.clk_i(clk_i),
			.rst_i(rst_i),
			.clear_i(!below_uv_level_i[i] || !regs_enabled),
			.run_i(below_uv_level_i[i] && regs_enabled),
			.tick_i(ms_tick_r),
			.limit_i(UV_LIMIT),
			.done_o(uv_done[i])
		);
	end

	// Faults are sticky; only the power-on reset clears them
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			uv_fault_r <= 1'b0;
		end else if (|uv_done) begin
			uv_fault_r <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			sc_fault_r <= 1'b0;
		end else if (regs_enabled && |below_sc_level_i) begin
			sc_fault_r <= 1'b1;
		end
	end

	// Reset pulse timer runs once the core rail is up
	ms_timer u_reset_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(state_r == PWR_OFF || powering_down),
		.run_i(state_r == PWR_UP && core_rail_ramp_done_i),
		.tick_i(ms_tick_r),
		.limit_i(reset_limit),
		.done_o(reset_timer_done)
	);

	// Shaping delay runs once the gate-high rail is up
	ms_timer u_shape_timer (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.clear_i(state_r == PWR_OFF || powering_down),
		.run_i(state_r != PWR_OFF && gate_high_rail_ramp_done_i),
		.tick_i(ms_tick_r),
		.limit_i(shape_limit),
		.done_o(shape_done)
	);

	// Released reset stays latched until power-down
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tcon_released_r <= 1'b0;
		end else if (powering_down || state_r == PWR_OFF) begin
			tcon_released_r <= 1'b0;
		end else if (reset_timer_done) begin
			tcon_released_r <= 1'b1;
		end
	end

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PWR_OFF: begin
				if (input_supply_above_lockout_i && supply_ok && !fault_any) begin
					state_nxt = PWR_UP;
				end
			end
			PWR_UP: begin
				if (fault_any || !supply_ok) begin
					state_nxt = PWR_DOWN;
				end else if (tcon_released_r && shape_done) begin
					state_nxt = PWR_ON;
				end
			end
			PWR_ON: begin
				if (fault_any || !supply_ok) begin
					state_nxt = PWR_DOWN;
				end
			end
			PWR_DOWN: begin
				if (!input_supply_above_lockout_i && !fault_any) begin
					state_nxt = PWR_OFF;
				end
			end
			default: begin
				state_nxt = PWR_OFF;
			end
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= PWR_OFF;
		end else begin
			state_r <= state_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			chip_enable_o <= 1'b0;
		end else begin
			chip_enable_o <= (state_nxt == PWR_UP || state_nxt == PWR_ON) && !fault_any;
		end
	end

	// Open-drain reset to the timing controller: only ever pulled low
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tcon_reset_n_o <= 1'b0;
			tcon_reset_n_oe_o <= 1'b1;
		end else begin
			tcon_reset_n_o <= 1'b0;
			tcon_reset_n_oe_o <= !tcon_released_r || powering_down;
		end
	end

	// Gate voltage shaping switches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pass_switch_o <= 1'b0;
			discharge_switch_o <= 1'b1;
		end else if (powering_down) begin
			pass_switch_o <= 1'b1;
			discharge_switch_o <= 1'b0;
		end else if (!shape_done || state_r == PWR_OFF) begin
			pass_switch_o <= 1'b0;
			discharge_switch_o <= 1'b1;
		end else if (shaping_ctrl_in_i) begin
			pass_switch_o <= 1'b1;
			discharge_switch_o <= 1'b0;
		end else begin
			pass_switch_o <= 1'b0;
			discharge_switch_o <= 1'b1;
		end
	end

	// Open-drain gate-driver reset in either mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gate_driver_reset_n_o <= 1'b0;
			gate_driver_reset_n_oe_o <= 1'b1;
		end else begin
			gate_driver_reset_n_o <= 1'b0;
			if (gip_mode) begin
				gate_driver_reset_n_oe_o <= !shape_done || powering_down
					|| state_r == PWR_OFF;
			end else begin
				gate_driver_reset_n_oe_o <= !input_supply_above_detect_i;
			end
		end
	end

	// Register writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			config_r <= CONFIG_RST;
			reset_width_r <= RESET_WIDTH_RST;
			shape_delay_r <= SHAPE_DELAY_RST;
			detect_r <= DETECT_RST;
			vcom_r <= VCOM_CODE_RST;
		end else if (wr_i) begin
			case (addr_i)
				CONFIG_ADDR: config_r <= wdata_i;
				RESET_WIDTH_ADDR: reset_width_r <= wdata_i;
				SHAPE_DELAY_ADDR: shape_delay_r <= wdata_i;
				DETECT_ADDR: detect_r <= wdata_i;
				VCOM_CODE_ADDR: vcom_r <= wdata_i[VCOM_BITS-1:0];
				default: begin
				end
			endcase
		end
	end

	// Analog settings driven from registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			detect_threshold_o <= DETECT_RST;
			vcom_code_o <= VCOM_CODE_RST;
			dac_sink_steps_o <= 8'h01;
		end else begin
			detect_threshold_o <= detect_r;
			vcom_code_o <= vcom_r;
			dac_sink_steps_o <= {1'b0, vcom_r} + 8'h01;
		end
	end

	// Status snapshot for the read path
	always_comb begin
		status_word = 8'h00;
		status_word[STAT_UV_BIT] = uv_fault_r;
		status_word[STAT_SC_BIT] = sc_fault_r;
		status_word[STAT_TCON_BIT] = tcon_reset_n_i;
		status_word[STAT_SHAPED_BIT] = shape_done;
		status_word[STAT_GDRV_BIT] = gate_driver_reset_n_i;
		status_word[STAT_STATE_LSB +: 2] = state_r;
	end

	// Register reads, data valid the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				CONFIG_ADDR: rdata_o <= config_r;
				RESET_WIDTH_ADDR: rdata_o <= reset_width_r;
				SHAPE_DELAY_ADDR: rdata_o <= shape_delay_r;
				DETECT_ADDR: rdata_o <= detect_r;
				VCOM_CODE_ADDR: rdata_o <= {1'b0, vcom_r};
				STATUS_ADDR: rdata_o <= status_word;
				default: rdata_o <= 8'h00;
			endcase
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule

/* hw/lcd_bias_pkg.sv */
package lcd_bias_pkg;
	// Register offsets
	localparam logic [7:0] CONFIG_ADDR = 8'h00;
	localparam logic [7:0] RESET_WIDTH_ADDR = 8'h08;
	localparam logic [7:0] SHAPE_DELAY_ADDR = 8'h0A;
	localparam logic [7:0] DETECT_ADDR = 8'h0B;
	localparam logic [7:0] VCOM_CODE_ADDR = 8'h20;
	localparam logic [7:0] STATUS_ADDR = 8'h21;
	// Reset values
	localparam logic [7:0] CONFIG_RST = 8'h00;
	localparam logic [7:0] RESET_WIDTH_RST = 8'h01;
	localparam logic [7:0] SHAPE_DELAY_RST = 8'h04;
	localparam logic [7:0] DETECT_RST = 8'h00;
	localparam logic [6:0] VCOM_CODE_RST = 7'h00;
	// Field positions
	localparam int THRESH_SEL_BIT = 0;
	localparam int GIP_MODE_BIT = 1;
	localparam int STAT_UV_BIT = 0;
	localparam int STAT_SC_BIT = 1;
	localparam int STAT_TCON_BIT = 2;
	localparam int STAT_SHAPED_BIT = 3;
	localparam int STAT_GDRV_BIT = 4;
	localparam int STAT_STATE_LSB = 5;
	// Timing
	localparam int CLK_HZ = 125_000_000;
	localparam int MS_PER_S = 1000;
	localparam int MS_CYCLES = CLK_HZ / MS_PER_S;
	localparam int UV_TIME_MS = 50;
	localparam int RESET_STEP_MS = 2;
	localparam int SHAPE_STEP_MS = 5;
	localparam int NUM_REGULATORS = 5;
	localparam int VCOM_BITS = 7;
	typedef enum logic [1:0] {
		PWR_OFF,
		PWR_UP,
		PWR_ON,
		PWR_DOWN
	} pwr_state_t;
endpackage

/* hw/ms_timer.sv */
`timescale 1ns/1ps
module ms_timer (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic clear_i,
	input wire logic run_i,
	input wire logic tick_i,
	input wire logic [7:0] limit_i,
	output logic done_o
);
	logic [7:0] count_r;

	// Counts millisecond ticks while running; clear holds it at zero
	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			count_r <= 8'h00;
		end else if (run_i && tick_i && (count_r < limit_i)) begin
			count_r <= count_r + 8'h01;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || clear_i) begin
			done_o <= 1'b0;
		end else if (run_i && (count_r >= limit_i)) begin
			done_o <= 1'b1;
		end
	end
endmodule

/* test/lcd_bias_asserts.sv */
`timescale 1ns/1ps
module lcd_bias_asserts
	import lcd_bias_pkg::*;
#(
	parameter int MS_CYCLES_P = 10,
	parameter int NUM_REG_P = 5
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic [NUM_REG_P-1:0] below_sc_level_i,
	input wire logic input_supply_above_detect_i,
	input logic tcon_reset_n_o,
	input logic tcon_reset_n_oe_o,
	input logic gate_driver_reset_n_o,
	input logic gate_driver_reset_n_oe_o,
	input logic pass_switch_o,
	input logic discharge_switch_o,
	input logic chip_enable_o,
	input logic [7:0] detect_threshold_o,
	input logic [6:0] vcom_code_o,
	input logic [7:0] dac_sink_steps_o
);
	logic gip_r;
	// Shadow of the mode bit, taken from the same bus writes
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gip_r <= 1'b0;
		end else if (wr_i && addr_i == CONFIG_ADDR) begin
			gip_r <= wdata_i[GIP_MODE_BIT];
		end
	end
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	sc_trip_a: assert property (
		|below_sc_level_i && chip_enable_o |-> ##[1:4] !chip_enable_o) else $error("short not tripped");
	sc_hold_a: assert property (
		|below_sc_level_i && chip_enable_o |-> ##4 !chip_enable_o [*8]) else $error("fault not held");
	tcon_od_a: assert property (tcon_reset_n_o == 1'b0) else $error("tcon pin driven high");
	gdrv_od_a: assert property (
		gate_driver_reset_n_o == 1'b0) else $error("gate driver pin driven high");
	tcon_latch_a: assert property (
		!tcon_reset_n_oe_o && chip_enable_o |=> !tcon_reset_n_oe_o || !chip_enable_o)
		else $error("tcon reset reasserted");
	switch_excl_a: assert property (
		pass_switch_o != discharge_switch_o) else $error("switches not complementary");
	up_forced_a: assert property (
		$rose(chip_enable_o) |-> discharge_switch_o && !pass_switch_o) else $error("up not forced");
	gdrv_conv_a: assert property (
		!gip_r |=> gate_driver_reset_n_oe_o == !$past(input_supply_above_detect_i))
		else $error("conventional pin wrong");
	gdrv_gip_a: assert property (
		gip_r && !chip_enable_o |=> gate_driver_reset_n_oe_o) else $error("panel pin released");
	vcom_wr_a: assert property (
		wr_i && addr_i == VCOM_CODE_ADDR |-> ##2
		{1'b0, vcom_code_o} == ($past(wdata_i, 2) & 8'h7F))
		else $error("code not taken");
	dac_steps_a: assert property (
		dac_sink_steps_o == {1'b0, vcom_code_o} + 8'h01) else $error("sink steps wrong");
	det_wr_a: assert property (
		wr_i && addr_i == DETECT_ADDR |-> ##2 detect_threshold_o == $past(wdata_i, 2))
		else $error("detect not taken");
	cover property ($fell(tcon_reset_n_oe_o));
	cover property ($fell(chip_enable_o) && gip_r);
	cover property (|below_sc_level_i && chip_enable_o);
endmodule
bind lcd_bias_supervisor_sequencer lcd_bias_asserts #(.MS_CYCLES_P(MS_CYCLES_P),
	.NUM_REG_P(NUM_REG_P)) chk_u (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .below_sc_level_i,
	.input_supply_above_detect_i, .tcon_reset_n_o, .tcon_reset_n_oe_o, .gate_driver_reset_n_o,
	.gate_driver_reset_n_oe_o, .pass_switch_o, .discharge_switch_o, .chip_enable_o,
	.detect_threshold_o, .vcom_code_o, .dac_sink_steps_o);

/* test/panel_pullup_model.sv */
`timescale 1ns/1ps
module panel_pullup_model (
	input wire logic tcon_reset_n_o,
	input wire logic tcon_reset_n_oe_o,
	input wire logic gate_driver_reset_n_o,
	input wire logic gate_driver_reset_n_oe_o,
	output logic tcon_pin_o,
	output logic gdrv_pin_o
);
	// Released open-drain pins sit at the pull-up level
	assign tcon_pin_o = tcon_reset_n_oe_o ? tcon_reset_n_o : 1'b1;
	assign gdrv_pin_o = gate_driver_reset_n_oe_o ? gate_driver_reset_n_o : 1'b1;
endmodule

/* test/test_lcd_bias_supervisor_sequencer.sv */
`timescale 1ns/1ps
module test_lcd_bias_supervisor_sequencer;
	import lcd_bias_pkg::*;
	localparam int MS = 10;
	logic clk_i, rst_i, wr_i, rd_i, input_supply_above_lockout_i, input_supply_above_detect_i;
	logic core_rail_ramp_done_i, gate_high_rail_ramp_done_i, shaping_ctrl_in_i, chip_enable_o;
	logic tcon_reset_n_i, tcon_reset_n_o, tcon_reset_n_oe_o, pass_switch_o, discharge_switch_o;
	logic gate_driver_reset_n_i, gate_driver_reset_n_o, gate_driver_reset_n_oe_o;
	logic [7:0] addr_i, wdata_i, rdata_o, detect_threshold_o, dac_sink_steps_o;
	logic [6:0] vcom_code_o;
	logic [4:0] below_uv_level_i, below_sc_level_i;
	logic [7:0] codes [3] = '{8'h00, 8'h40, 8'h7F};
	int failures = 0;
	int comparisons = 0;
	lcd_bias_supervisor_sequencer #(.MS_CYCLES_P(MS), .NUM_REG_P(5)) dut_u (.clk_i, .rst_i,
		.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .below_uv_level_i, .below_sc_level_i,
		.input_supply_above_lockout_i, .input_supply_above_detect_i, .core_rail_ramp_done_i,
		.gate_high_rail_ramp_done_i, .shaping_ctrl_in_i, .tcon_reset_n_i, .tcon_reset_n_o,
		.tcon_reset_n_oe_o, .gate_driver_reset_n_i, .gate_driver_reset_n_o,
		.gate_driver_reset_n_oe_o, .pass_switch_o, .discharge_switch_o, .chip_enable_o,
		.detect_threshold_o, .vcom_code_o, .dac_sink_steps_o);
	panel_pullup_model pins_u (.tcon_reset_n_o, .tcon_reset_n_oe_o, .gate_driver_reset_n_o,
		.gate_driver_reset_n_oe_o, .tcon_pin_o(tcon_reset_n_i), .gdrv_pin_o(gate_driver_reset_n_i));
	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	task automatic report_and_stop;
		$display("comparisons=%0d failures=%0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [7:0] g, e);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_win(input int n, lo, hi);
		comparisons++;
		if (n < lo || n > hi) begin
			failures++;
			$display("MISMATCH t=%0t got=%h exp=%h..%h", $time, n, lo, hi);
		end
	endtask
	task automatic wr(input logic [7:0] a, d);
		@(posedge clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, m, e);
		@(posedge clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		chk(rdata_o & m, e);
		@(posedge clk_i);
	endtask
	// Order: timing-controller pin, gate-driver pin, pass, discharge, enable
	task automatic pins(input logic [4:0] e);
		repeat (3) @(posedge clk_i);
		@(negedge clk_i);
		chk({3'b000, tcon_reset_n_i, gate_driver_reset_n_i, pass_switch_o, discharge_switch_o,
			chip_enable_o}, {3'b000, e});
		@(posedge clk_i);
	endtask
	task automatic wait_hi(input bit on_pass, output int n);
		n = 0;
		while ((on_pass ? pass_switch_o : tcon_reset_n_i) !== 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic power_up(input logic [7:0] cfg, input int w, d);
		int n;
		rst_i <= 1'b1;
		{wr_i, rd_i, addr_i, wdata_i} <= 18'h0_0000;
		{input_supply_above_lockout_i, input_supply_above_detect_i} <= 2'b00;
		{core_rail_ramp_done_i, gate_high_rail_ramp_done_i} <= 2'b00;
		{below_uv_level_i, below_sc_level_i} <= 10'h000;
		shaping_ctrl_in_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		if (w < 0) return;
		wr(CONFIG_ADDR, cfg);
		wr(RESET_WIDTH_ADDR, 8'(w));
		wr(SHAPE_DELAY_ADDR, 8'(d));
		{input_supply_above_lockout_i, input_supply_above_detect_i} <= 2'b11;
		pins({1'b0, !cfg[GIP_MODE_BIT], 3'b011});
		core_rail_ramp_done_i <= 1'b1;
		wait_hi(1'b0, n);
		chk_win(n, (w + 1) * 2 * MS - MS, (w + 1) * 2 * MS + 4);
		chk(gate_driver_reset_n_i, !cfg[GIP_MODE_BIT]);
		gate_high_rail_ramp_done_i <= 1'b1;
		wait_hi(1'b1, n);
		chk_win(n, d * 5 * MS - MS, d * 5 * MS + 4);
		pins(5'b11101);
	endtask
	initial begin
		#200_000;
		failures++;
		report_and_stop();
	end
	initial begin
		power_up(8'h00, -1, 0);
		rdchk(CONFIG_ADDR, 8'hFF, 8'h00);
		rdchk(RESET_WIDTH_ADDR, 8'hFF, 8'h01);
		rdchk(SHAPE_DELAY_ADDR, 8'hFF, 8'h04);
		wr(STATUS_ADDR, 8'hFF);
		rdchk(STATUS_ADDR, 8'hFF, 8'h00);
		rdchk(8'h55, 8'hFF, 8'h00);
		wr(DETECT_ADDR, 8'h9C);
		rdchk(DETECT_ADDR, 8'hFF, 8'h9C);
		chk(detect_threshold_o, 8'h9C);
		foreach (codes[i]) begin
			wr(VCOM_CODE_ADDR, codes[i]);
			rdchk(VCOM_CODE_ADDR, 8'h7F, codes[i]);
			chk({1'b0, vcom_code_o}, codes[i]);
			chk(dac_sink_steps_o, codes[i] + 8'h01);
		end
		power_up(8'h00, 0, 7);
		shaping_ctrl_in_i <= 1'b0;
		pins(5'b11011);
		shaping_ctrl_in_i <= 1'b1;
		core_rail_ramp_done_i <= 1'b0;
		input_supply_above_detect_i <= 1'b0;
		pins(5'b10101);
		input_supply_above_lockout_i <= 1'b0;
		pins(5'b00010);
		power_up(8'h03, 7, 0);
		input_supply_above_detect_i <= 1'b0;
		shaping_ctrl_in_i <= 1'b0;
		pins(5'b00100);
		power_up(8'h00, 0, 0);
		below_sc_level_i <= 5'h10;
		@(posedge clk_i);
		below_sc_level_i <= 5'h00;
		wr(CONFIG_ADDR, 8'h00);
		pins(5'b01100);
		rdchk(STATUS_ADDR, 8'h03, 8'h02);
		power_up(8'h00, 0, 0);
		repeat (2) begin
			below_uv_level_i <= 5'h04;
			repeat (40 * MS) @(posedge clk_i);
			below_uv_level_i <= 5'h00;
			@(posedge clk_i);
		end
		pins(5'b11101);
		below_uv_level_i <= 5'h04;
		repeat (49 * MS) @(posedge clk_i);
		chk(chip_enable_o, 8'h01);
		repeat (4 * MS) @(posedge clk_i);
		pins(5'b01100);
		rdchk(STATUS_ADDR, 8'h01, 8'h01);
		report_and_stop();
	end
endmodule
